// file: design/ldtp_pkg.sv
// Package for the line driver test pattern and self-test extension block.
// Assumes a 50 MHz APB clock and 32-bit APB data with registers on word indexes.
// Contract
// - Count errored self-test nibbles; read-only in bits 15:8 of the test register.
// - Clear the error count to zero whenever a new self-test run starts.
// - Error count saturates at all ones and holds until the next restart.
// - Continuous bit set: pseudo-random data sent with no gap between packets.
// - Continuous mode acts only while the self-test control in phy control runs.
// - Pattern enable 1 turns the fixed test pattern generator on; 0 turns it off.
// - Idle gap between test sequences: 15 us if gap select is 1, else 10 us.
// - Select 00 data+form a, 01 data+form b, 10 link pulses, 11 Manchester ones.
// - Jabber disable 1 suppresses jabber; 0 keeps jabber protection active.
`default_nettype none
package ldtp_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word indexes, byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_PHY_CONTROL = 8'h19;
  localparam logic [7:0] IDX_TEN_MEG_CONTROL = 8'h1a;
  localparam logic [7:0] IDX_LINE_DRIVER_TEST = 8'h1b;
  localparam logic [11:0] ADDR_PHY_CONTROL = {2'h0, IDX_PHY_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_TEN_MEG_CONTROL = {2'h0, IDX_TEN_MEG_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_LINE_DRIVER_TEST = {2'h0, IDX_LINE_DRIVER_TEST, 2'h0};

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int ERR_COUNT_LSB = 8;
  localparam int ERR_COUNT_W = 8;
  localparam int BIT_CONTINUOUS = 5;
  localparam int BIT_PATTERN_ENABLE = 4;
  localparam int BIT_GAP_SELECT = 2;
  localparam int PATTERN_SELECT_LSB = 0;
  localparam int BIT_SELFTEST_RUN = 8;
  localparam int BIT_JABBER_DISABLE = 0;
  localparam logic [15:0] TEST_REG_WRITE_MASK = 16'h0037;
  localparam logic [15:0] RESET_TEST_REG = 16'h0000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int GAP_SHORT_US = 10;
  localparam int GAP_LONG_US = 15;
  localparam logic [9:0] GAP_SHORT_CYCLES = 10'(GAP_SHORT_US * CLK_MHZ);
  localparam logic [9:0] GAP_LONG_CYCLES = 10'(GAP_LONG_US * CLK_MHZ);
  localparam int BIT_NS = 100;
  localparam int CLK_NS = 20;
  localparam logic [3:0] BIT_CYCLES = 4'((BIT_NS + CLK_NS - 1) / CLK_NS);

  // ---------------------------------------------------------------------------
  // Modes and line symbols
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF, MODE_DATA_A, MODE_DATA_B, MODE_PULSE, MODE_ONES, MODE_PRBS
  } ldtp_mode_e;

  typedef enum logic [2:0] {
    SYM_IDLE, SYM_DATA, SYM_EOP_A, SYM_EOP_B, SYM_PULSE, SYM_ONE, SYM_NORMAL
  } ldtp_sym_e;

endpackage
`default_nettype wire

// file: design/ldtp_seq_if.sv
// Interface between the register side and the pattern sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ldtp_seq_if;
  import ldtp_pkg::*;
  ldtp_mode_e mode;
  logic no_gap;
  logic [9:0] gap_cycles;
  ldtp_sym_e sym;
  logic bit_val;
  logic strobe;
  modport ctl (output mode, no_gap, gap_cycles, input sym, bit_val, strobe);
  modport seq (input mode, no_gap, gap_cycles, output sym, bit_val, strobe);
endinterface
`default_nettype wire

// file: design/ldtp_seq.sv
// Pattern sequencer: bursts of symbols at the 10 Mb/s bit rate with idle gaps.
// Assumes the controller holds mode steady while a pattern is wanted.
`timescale 1ns/1ps
`default_nettype none
module ldtp_seq
  import ldtp_pkg::*;
#(
  parameter int DATA_BITS = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  ldtp_seq_if.seq s
);

  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_TAIL, ST_GAP} ldtp_state_e;

  ldtp_state_e state;
  ldtp_mode_e mode_q;
  logic [3:0] tcnt;
  logic [15:0] bcnt;
  logic [9:0] gcnt;
  logic [14:0] lfsr;
  logic tick;

  // ---------------------------------------------------------------------------
  // Bit timer
  // ---------------------------------------------------------------------------
  // Bit strobe every bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt <= 4'h0;
    end else if (tcnt == BIT_CYCLES - 4'h1) begin
      tcnt <= 4'h0;
    end else begin
      tcnt <= tcnt + 4'h1;
    end
  end
  assign tick = (tcnt == BIT_CYCLES - 4'h1);

  // Pseudo-random source, x^15 + x^14 + 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= 15'h7fff;
    end else if (tick && state == ST_BURST) begin
      lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
    end
  end

  // ---------------------------------------------------------------------------
  // Burst and gap sequencing
  // ---------------------------------------------------------------------------
  // State walk; a mode change restarts from idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      mode_q <= MODE_OFF;
      bcnt <= 16'h0;
      gcnt <= 10'h0;
    end else begin
      mode_q <= s.mode;
      if (s.mode != mode_q || s.mode == MODE_OFF) begin
        state <= ST_IDLE;
        bcnt <= 16'h0;
        gcnt <= 10'h0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (tick) begin
              state <= ST_BURST;
            end
          end
          ST_BURST: begin
            if (tick) begin
              if (s.mode == MODE_ONES) begin
                bcnt <= 16'h0;
              end else if (s.mode == MODE_PULSE) begin
                state <= ST_GAP;
              end else if (bcnt == 16'(DATA_BITS - 1)) begin
                bcnt <= 16'h0;
                if (s.mode == MODE_PRBS) begin
                  state <= s.no_gap ? ST_BURST : ST_GAP;
                end else begin
                  state <= ST_TAIL;
                end
              end else begin
                bcnt <= bcnt + 16'h1;
              end
            end
          end
          ST_TAIL: begin
            if (tick) begin
              state <= ST_GAP;
            end
          end
          ST_GAP: begin
            // Gap counted in clock cycles
            if (gcnt == s.gap_cycles - 10'h1) begin
              gcnt <= 10'h0;
              state <= ST_BURST;
            end else begin
              gcnt <= gcnt + 10'h1;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Symbol out
  // ---------------------------------------------------------------------------
  // Symbol for the current bit time
  always_comb begin
    s.sym = SYM_IDLE;
    s.bit_val = 1'b0;
    if (state == ST_BURST) begin
      unique case (s.mode)
        MODE_DATA_A, MODE_DATA_B, MODE_PRBS: begin
          s.sym = SYM_DATA;
          s.bit_val = lfsr[14];
        end
        MODE_PULSE: s.sym = SYM_PULSE;
        MODE_ONES: begin
          s.sym = SYM_ONE;
          s.bit_val = 1'b1;
        end
        default: s.sym = SYM_IDLE;
      endcase
    end else if (state == ST_TAIL) begin
      s.sym = (s.mode == MODE_DATA_B) ? SYM_EOP_B : SYM_EOP_A;
    end
  end
  assign s.strobe = tick;

endmodule // ldtp_seq
`default_nettype wire

// file: design/ldtp_top.sv
// Top of the line driver test pattern and self-test extension block.
// Assumes an APB master on pclk and a line encoder that takes one symbol per strobe.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ldtp_top
  import ldtp_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_BITS = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Normal transmit traffic and self-test checker
  input wire logic mac_tx_en,
  input wire logic mac_tx_bit,
  input wire logic selftest_nibble_err,
  // Line encoder side
  output ldtp_sym_e line_sym,
  output logic line_bit,
  output logic line_strobe,
  // Status toward other blocks
  output logic jabber_enable,
  output logic selftest_active
);

  logic selftest_continuous;
  logic test_pattern_enable;
  logic test_pattern_gap_select;
  logic [1:0] test_pattern_select;
  logic jabber_disable;
  logic selftest_run;
  logic [ERR_COUNT_W-1:0] selftest_error_count;
  logic setup;
  logic access;
  logic wr_test;
  logic wr_phy;
  logic wr_ten;
  logic start_pulse;
  logic mapped;
  logic [15:0] rd_value;
  logic [15:0] wdata16;
  ldtp_mode_e next_mode;

  ldtp_seq_if sif ();

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  // Setup and completing access phases
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wdata16 = pwdata[15:0];
  assign wr_test = access && pwrite && paddr == ADDR_W'(ADDR_LINE_DRIVER_TEST);
  assign wr_phy = access && pwrite && paddr == ADDR_W'(ADDR_PHY_CONTROL);
  assign wr_ten = access && pwrite && paddr == ADDR_W'(ADDR_TEN_MEG_CONTROL);
  assign mapped = paddr == ADDR_W'(ADDR_LINE_DRIVER_TEST)
               || paddr == ADDR_W'(ADDR_PHY_CONTROL)
               || paddr == ADDR_W'(ADDR_TEN_MEG_CONTROL);

  // No wait state: ready follows each setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_value = 16'h0000;
    if (paddr == ADDR_W'(ADDR_LINE_DRIVER_TEST)) begin
      rd_value[ERR_COUNT_LSB +: ERR_COUNT_W] = selftest_error_count;
      rd_value[BIT_CONTINUOUS] = selftest_continuous;
      rd_value[BIT_PATTERN_ENABLE] = test_pattern_enable;
      rd_value[BIT_GAP_SELECT] = test_pattern_gap_select;
      rd_value[PATTERN_SELECT_LSB +: 2] = test_pattern_select;
    end else if (paddr == ADDR_W'(ADDR_PHY_CONTROL)) begin
      rd_value[BIT_SELFTEST_RUN] = selftest_run;
    end else if (paddr == ADDR_W'(ADDR_TEN_MEG_CONTROL)) begin
      rd_value[BIT_JABBER_DISABLE] = jabber_disable;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {16'h0000, rd_value};
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Test register writable fields; reserved bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selftest_continuous <= RESET_TEST_REG[BIT_CONTINUOUS];
      test_pattern_enable <= RESET_TEST_REG[BIT_PATTERN_ENABLE];
      test_pattern_gap_select <= RESET_TEST_REG[BIT_GAP_SELECT];
      test_pattern_select <= RESET_TEST_REG[PATTERN_SELECT_LSB +: 2];
    end else if (wr_test && pstrb[0]) begin
      selftest_continuous <= wdata16[BIT_CONTINUOUS];
      test_pattern_enable <= wdata16[BIT_PATTERN_ENABLE];
      test_pattern_gap_select <= wdata16[BIT_GAP_SELECT];
      test_pattern_select <= wdata16[PATTERN_SELECT_LSB +: 2];
    end
  end

  // Self-test run bit; a 0 to 1 write starts a new run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selftest_run <= 1'b0;
    end else if (wr_phy && pstrb[1]) begin
      selftest_run <= wdata16[BIT_SELFTEST_RUN];
    end
  end
  assign start_pulse = wr_phy && pstrb[1] && wdata16[BIT_SELFTEST_RUN] && !selftest_run;

  // Jabber disable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jabber_disable <= 1'b0;
    end else if (wr_ten && pstrb[0]) begin
      jabber_disable <= wdata16[BIT_JABBER_DISABLE];
    end
  end

  // Jabber protection follows the disable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jabber_enable <= 1'b1;
    end else begin
      jabber_enable <= !jabber_disable;
    end
  end

  // ---------------------------------------------------------------------------
  // Self-test error counter
  // ---------------------------------------------------------------------------
  // Restart clears, errors count up and stick at all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selftest_error_count <= '0;
    end else if (start_pulse) begin
      selftest_error_count <= '0;
    end else if (selftest_run && selftest_nibble_err) begin
      if (selftest_error_count != {ERR_COUNT_W{1'b1}}) begin
        selftest_error_count <= selftest_error_count + 1'b1;
      end
    end
  end

  // Run status output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selftest_active <= 1'b0;
    end else begin
      selftest_active <= selftest_run;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode selection and sequencer
  // ---------------------------------------------------------------------------
  // Self-test first, then fixed patterns, else normal traffic
  always_comb begin
    next_mode = MODE_OFF;
    if (selftest_run) begin
      next_mode = MODE_PRBS;
    end else if (test_pattern_enable) begin
      unique case (test_pattern_select)
        2'h0: next_mode = MODE_DATA_A;
        2'h1: next_mode = MODE_DATA_B;
        2'h2: next_mode = MODE_PULSE;
        2'h3: next_mode = MODE_ONES;
      endcase
    end
  end

  // Sequencer steering
  assign sif.mode = next_mode;
  assign sif.no_gap = selftest_run && selftest_continuous;
  assign sif.gap_cycles = (test_pattern_enable && !selftest_run && test_pattern_gap_select)
                          ? GAP_LONG_CYCLES : GAP_SHORT_CYCLES;

  ldtp_seq #(
    .DATA_BITS(DATA_BITS)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .s(sif.seq)
  );

  // ---------------------------------------------------------------------------
  // Line outputs
  // ---------------------------------------------------------------------------
  // Registered symbol toward the line encoder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_sym <= SYM_IDLE;
      line_bit <= 1'b0;
      line_strobe <= 1'b0;
    end else if (next_mode == MODE_OFF) begin
      line_sym <= mac_tx_en ? SYM_NORMAL : SYM_IDLE;
      line_bit <= mac_tx_bit;
      line_strobe <= sif.strobe;
    end else begin
      line_sym <= sif.sym;
      line_bit <= sif.bit_val;
      line_strobe <= sif.strobe;
    end
  end

endmodule // ldtp_top
`default_nettype wire

// file: testbench/ldtp_chk.sv
// Port checker for ldtp_top.
// Assumes a bind onto ldtp_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ldtp_chk
  import ldtp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and status
  input var ldtp_sym_e line_sym,
  input wire logic line_bit,
  input wire logic line_strobe,
  input wire logic mac_tx_bit,
  input wire logic jabber_enable,
  input wire logic selftest_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Address decode
  logic mapped;
  assign mapped = paddr == 12'h064 || paddr == 12'h068 || paddr == 12'h06c;
  // Bus steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_jab_wr;
    psel && penable && pready && pwrite && paddr == 12'h068 && pstrb[0];
  endsequence
  sequence s_run_wr;
    psel && penable && pready && pwrite && paddr == 12'h064 && pstrb[1];
  endsequence
  chk_ready_after_setup:
    assert property (s_setup |=> pready) else $error("no ready after setup");
  chk_ready_single:
    assert property (pready |=> !pready) else $error("ready held too long");
  chk_unmapped_err:
    assert property (pready && !mapped |-> pslverr && prdata == 32'h0) else $error("unmapped");
  chk_mapped_ok:
    assert property (pready && mapped |-> !pslverr && prdata[31:16] == 16'h0)
      else $error("mapped access");
  chk_reserved_zero:
    assert property (pready && !pwrite && paddr == 12'h06c |-> prdata[7:6] == 2'h0 && !prdata[3])
      else $error("reserved bits set");
  chk_jabber_follow:
    assert property (s_jab_wr |-> ##2 jabber_enable == !$past(pwdata[0], 2))
      else $error("jabber enable wrong");
  chk_active_follow:
    assert property (s_run_wr |-> ##2 selftest_active == $past(pwdata[8], 2))
      else $error("self-test active wrong");
  chk_strobe_spacing:
    assert property (line_strobe |=> !line_strobe [*4]) else $error("strobe too early");
  chk_normal_bit:
    assert property (line_sym == SYM_NORMAL |-> line_bit == $past(mac_tx_bit))
      else $error("normal traffic bit not passed through");
  chk_ones_bit:
    assert property (line_sym == SYM_ONE |-> line_bit) else $error("ones pattern bit low");
endmodule // ldtp_chk
`default_nettype wire

// file: testbench/ldtp_line_model.sv
// Far side of the line: records symbols seen and idle gap lengths.
// Assumes one symbol value per clock from ldtp_top.
`timescale 1ns/1ps
`default_nettype none
module ldtp_line_model
  import ldtp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line and bench control
  input var ldtp_sym_e line_sym,
  input wire logic clr,
  output logic [7:0] seen,
  output logic [15:0] last_gap,
  output logic [15:0] max_gap
);
  logic [15:0] run;
  // Symbol flags and idle run lengths
  always_ff @(posedge pclk) begin
    if (!presetn || clr) begin
      seen <= 8'h00;
      run <= 16'h0;
      last_gap <= 16'h0;
      max_gap <= 16'h0;
    end else begin
      seen[line_sym] <= 1'b1;
      if (line_sym == SYM_IDLE) begin
        run <= run + 16'h1;
      end else begin
        run <= 16'h0;
        if (run != 16'h0) last_gap <= run;
        if (run > max_gap) max_gap <= run;
      end
    end
  end
endmodule // ldtp_line_model
`default_nettype wire

// file: testbench/test_line_driver_test_pattern_bist_ext.sv
// Bench for ldtp_top: register access, self-test count, line patterns.
// Assumes ldtp_chk and ldtp_line_model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_line_driver_test_pattern_bist_ext;
  import ldtp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
  logic tx_en = 0, tx_bit = 0, nib_err = 0, pready, pslverr, lstr, lbit, jab_en, st_act;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic [3:0] pstrb = '0;
  logic [7:0] seen;
  logic [15:0] last_gap, max_gap;
  ldtp_sym_e lsym;
  ldtp_sym_e pat_sym [4] = '{SYM_EOP_A, SYM_EOP_B, SYM_PULSE, SYM_ONE};
  int bad_count = 0, check_count = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) tx_bit <= 1'($urandom);
  ldtp_top #(.ADDR_W(12), .DATA_BITS(8)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mac_tx_en(tx_en), .mac_tx_bit(tx_bit), .selftest_nibble_err(nib_err),
    .line_sym(lsym), .line_bit(lbit), .line_strobe(lstr), .jabber_enable(jab_en),
    .selftest_active(st_act));
  ldtp_line_model i_line (.pclk(pclk), .presetn(presetn), .line_sym(lsym), .clr(clr),
    .seen(seen), .last_gap(last_gap), .max_gap(max_gap));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic is_mapped(input logic [11:0] a);
    return a == 12'h064 || a == 12'h068 || a == 12'h06c;
  endfunction
  // Test register value from error count and written low byte
  function automatic logic [31:0] exp_test(input int n, input logic [7:0] low);
    return {16'h0, (n > 255) ? 8'hff : 8'(n), low & 8'h37};
  endfunction
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: no ready", $time);
      final_report();
    end else begin
      cmp(32'(pslverr), 32'(!is_mapped(a)), "slave error");
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rv, e, "read data");
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge pclk);
      nib_err <= 1'b1;
      @(posedge pclk);
      nib_err <= 1'b0;
    end
  endtask
  task automatic watch(input int n);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  // Main sequence
  initial begin
    int n;
    logic [15:0] d;
    void'($urandom(69711));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h06c, 32'h0);
    rd(12'h068, 32'h0);
    rd(12'h064, 32'h0);
    rd(12'h070, 32'h0);
    rd(12'h100, 32'h0);
    $display("reset test done");
    repeat (4) begin
      d = 16'($urandom) & 16'hff37;
      apb(1'b1, 12'h06c, {16'h0, d});
      rd(12'h06c, exp_test(0, d[7:0]));
    end
    apb(1'b1, 12'h068, 32'h1);
    repeat (2) @(posedge pclk);
    cmp(32'(jab_en), 32'h0, "jabber enable");
    apb(1'b1, 12'h068, 32'h0);
    repeat (2) @(posedge pclk);
    cmp(32'(jab_en), 32'h1, "jabber enable");
    $display("register test done");
    apb(1'b1, 12'h06c, 32'h0);
    apb(1'b1, 12'h064, 32'h100);
    n = $urandom_range(40, 1);
    errs(n);
    rd(12'h06c, exp_test(n, 8'h0));
    apb(1'b1, 12'h06c, 32'hff00);
    rd(12'h06c, exp_test(n, 8'h0));
    errs(300);
    rd(12'h06c, exp_test(300, 8'h0));
    apb(1'b1, 12'h064, 32'h0);
    apb(1'b1, 12'h064, 32'h100);
    rd(12'h06c, exp_test(0, 8'h0));
    apb(1'b1, 12'h064, 32'h0);
    $display("error count test done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 12'h06c, 32'h10 | s);
      watch(1200);
      cmp(32'(seen[pat_sym[s]]), 32'h1, "pattern symbol");
    end
    apb(1'b1, 12'h06c, 32'h12);
    watch(1200);
    cmp(32'(last_gap), 32'd500, "short gap");
    apb(1'b1, 12'h06c, 32'h16);
    watch(1700);
    cmp(32'(last_gap), 32'd750, "long gap");
    apb(1'b1, 12'h06c, 32'h07);
    tx_en <= 1'b1;
    watch(600);
    cmp(32'(seen[SYM_NORMAL]), 32'h1, "normal traffic");
    cmp(32'(seen & 8'h3e), 32'h0, "pattern while off");
    $display("pattern test done");
    apb(1'b1, 12'h06c, 32'h20);
    watch(600);
    cmp(32'(seen[SYM_DATA]), 32'h0, "continuous without run");
    apb(1'b1, 12'h068, 32'h1);
    apb(1'b1, 12'h064, 32'h100);
    repeat (100) @(posedge pclk);
    watch(1500);
    cmp({max_gap, last_gap}, 32'h0, "continuous gap");
    cmp(32'(seen[SYM_DATA]), 32'h1, "continuous data");
    apb(1'b1, 12'h06c, 32'h0);
    watch(1500);
    cmp(32'(last_gap), 32'd500, "self-test gap");
    $display("continuous test done");
    final_report();
  end
endmodule // test_line_driver_test_pattern_bist_ext
bind ldtp_top ldtp_chk #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_sym(line_sym), .line_bit(line_bit), .mac_tx_bit(mac_tx_bit),
  .line_strobe(line_strobe), .jabber_enable(jabber_enable),
  .selftest_active(selftest_active));
`default_nettype wire
